// ===== verilog/vlan_filter_map.svh
// register offsets, field positions, reset values and sizes of the vlan filter
`ifndef VLAN_FILTER_MAP_SVH
`define VLAN_FILTER_MAP_SVH

`define NUM_PORTS          8
`define PORT_IDX_W         3
`define NUM_ENTRIES        8
`define VID_W              12

`define ADDR_PORT_DEFAULT_VLAN_ID_BASE     8'h00
`define ADDR_ING_FILTER    8'h20
`define ADDR_EGR_TAGGED    8'h24
`define ADDR_DEF_MEMBERS   8'h28
`define ADDR_STP_STATUS    8'h2C
`define ADDR_FWD_COUNT     8'h30
`define ADDR_DROP_COUNT    8'h34
`define ADDR_VLAN_BASE     8'h40

`define ENTRY_VID_LSB      0
`define ENTRY_MEM_LSB      16
`define ENTRY_VALID_BIT    31
`define FILT_TAG_LSB       0
`define FILT_UNTAG_LSB     8
`define TCI_PCP_LSB        13
`define TCI_DEI_BIT        12

`define DEFAULT_VID        12'h001
`define NULL_VID           12'h000
`define RST_DEF_MEMBERS    8'hFF
`define RST_EGR_TAGGED     8'h00
`define RST_ING_FILTER     16'h0000
`define TPID_8021Q         16'h8100

`endif

// ===== verilog/vlan_filter_pkg.sv
// types shared by the vlan filter modules
`include "vlan_filter_map.svh"

package vlan_filter_pkg;
  typedef logic [`VID_W-1:0]      vid_t;
  typedef logic [`NUM_PORTS-1:0]  port_mask_t;
  typedef logic [`PORT_IDX_W-1:0] port_idx_t;
  typedef logic [`NUM_ENTRIES-1:0] entry_mask_t;
  typedef struct packed {
    logic       valid;
    vid_t       vid;
    port_mask_t members;
  } vlan_entry_t;
endpackage : vlan_filter_pkg

// ===== verilog/vlan_lookup_if.sv
// lookup path between the filter core and the vlan table matcher
`timescale 1ns/1ps
interface vlan_lookup_if;
  import vlan_filter_pkg::*;
  vlan_entry_t table_q [`NUM_ENTRIES];
  vid_t        query_vid;
  logic        hit;
  port_mask_t  members;
  port_mask_t  other_members;
  entry_mask_t stp_enable;

  modport requester (output table_q, query_vid, input hit, members, other_members, stp_enable);
  modport matcher   (input table_q, query_vid, output hit, members, other_members, stp_enable);
endinterface : vlan_lookup_if

// ===== verilog/vlan_match.sv
// vlan table matcher: membership lookup and spanning-tree enables for overlapping groups
`timescale 1ns/1ps
module vlan_match (
  vlan_lookup_if.matcher lk
);
  import vlan_filter_pkg::*;

  function automatic logic overlaps(input vlan_entry_t a, input vlan_entry_t b);
    overlaps = a.valid && b.valid && ((a.members & b.members) != '0);
  endfunction : overlaps

  always_comb begin
    lk.hit           = 1'b0;
    lk.members       = '0;
    lk.other_members = '0;
    lk.stp_enable    = '0;
    for (int i = 0; i < `NUM_ENTRIES; i++) begin
      // several entries may carry one vid; their port sets add up
      if (lk.table_q[i].valid && lk.table_q[i].vid == lk.query_vid) begin
        lk.hit     = 1'b1;
        lk.members = lk.members | lk.table_q[i].members;
      end
      if (lk.table_q[i].valid && lk.table_q[i].vid != `DEFAULT_VID) begin
        lk.other_members = lk.other_members | lk.table_q[i].members;
      end
      lk.stp_enable[i] = lk.table_q[i].valid;
      for (int j = 0; j < `NUM_ENTRIES; j++) begin
        // only the lowest vid among groups that share ports keeps spanning tree
        if (j != i && overlaps(lk.table_q[i], lk.table_q[j]) && lk.table_q[j].vid < lk.table_q[i].vid) begin
          lk.stp_enable[i] = 1'b0;
        end
      end
    end
  end
endmodule : vlan_match

// ===== verilog/vlan_filter.sv
// per-port vlan classification, ingress filter, membership forwarding and egress tagging
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "vlan_filter_map.svh"

module vlan_filter (
  input  wire  logic                     SYS_CLK,
  input  wire  logic                     RESETN,
  input  wire  logic [7:0]               WB_ADR_I,
  input  wire  logic [31:0]              WB_DAT_I,
  output       logic [31:0]              WB_DAT_O,
  input  wire  logic [3:0]               WB_SEL_I,
  input  wire  logic                     WB_WE_I,
  input  wire  logic                     WB_CYC_I,
  input  wire  logic                     WB_STB_I,
  output       logic                     WB_ACK_O,
  input  wire  logic                     RX_VALID,
  input  wire  vlan_filter_pkg::port_idx_t RX_PORT,
  input  wire  logic                     RX_TAGGED,
  input  wire  logic [15:0]              RX_TCI,
  input  wire  vlan_filter_pkg::port_mask_t PORT_BLOCKING,
  output       logic                     FWD_VALID,
  output       logic                     FWD_DROP,
  output       vlan_filter_pkg::vid_t    FWD_VID,
  output       vlan_filter_pkg::port_mask_t FWD_MASK,
  output       vlan_filter_pkg::port_mask_t FWD_ADD_TAG,
  output       vlan_filter_pkg::port_mask_t FWD_STRIP_TAG,
  output       logic [31:0]              FWD_TAG,
  output       vlan_filter_pkg::entry_mask_t STP_VLAN_ENABLE
);
  import vlan_filter_pkg::*;

  // register file
  vid_t        port_default_vlan_id      [`NUM_PORTS];
  vid_t        next_port_default_vlan_id [`NUM_PORTS];
  logic [15:0] ing_filter;
  logic [15:0] next_ing_filter;
  port_mask_t  egr_tagged;
  port_mask_t  next_egr_tagged;
  port_mask_t  def_members;
  port_mask_t  next_def_members;
  vlan_entry_t table_q    [`NUM_ENTRIES];
  vlan_entry_t next_table [`NUM_ENTRIES];
  logic [31:0] fwd_count;
  logic [31:0] next_fwd_count;
  logic [31:0] drop_count;
  logic [31:0] next_drop_count;

  // bus slave
  logic [31:0] next_dat_o;
  logic        next_ack;
  logic        wr_en;
  logic [31:0] rd_word;

  // decision
  logic        next_fwd_valid;
  logic        next_fwd_drop;
  vid_t        next_fwd_vid;
  port_mask_t  next_fwd_mask;
  port_mask_t  next_add_tag;
  port_mask_t  next_strip_tag;
  logic [31:0] next_fwd_tag;
  entry_mask_t next_stp_enable;
  vid_t        cls_vid;
  port_mask_t  vlan_ports;
  port_mask_t  src_bit;
  logic        filtered;
  logic        use_port_default_vlan_id;
  logic        drop;

  vlan_lookup_if lk ();

  vlan_match u_match (
    .lk (lk.matcher)
  );

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge_bytes[b*8 +: 8] = sel[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction : merge_bytes

  function automatic logic [31:0] pack_entry(input vlan_entry_t e);
    pack_entry                                   = 32'h0000_0000;
    pack_entry[`ENTRY_VID_LSB +: `VID_W]         = e.vid;
    pack_entry[`ENTRY_MEM_LSB +: `NUM_PORTS]     = e.members;
    pack_entry[`ENTRY_VALID_BIT]                 = e.valid;
  endfunction : pack_entry

  function automatic vlan_entry_t unpack_entry(input logic [31:0] w);
    unpack_entry.vid     = w[`ENTRY_VID_LSB +: `VID_W];
    unpack_entry.members = w[`ENTRY_MEM_LSB +: `NUM_PORTS];
    unpack_entry.valid   = w[`ENTRY_VALID_BIT];
  endfunction : unpack_entry

  always_comb begin
    for (int i = 0; i < `NUM_ENTRIES; i++) begin
      lk.table_q[i] = table_q[i];
    end
    lk.query_vid = cls_vid;
  end

  // register read mux; holes read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      if (WB_ADR_I == `ADDR_PORT_DEFAULT_VLAN_ID_BASE + 8'(p * 4)) begin
        rd_word = {20'h00000, port_default_vlan_id[p]};
      end
    end
    for (int i = 0; i < `NUM_ENTRIES; i++) begin
      if (WB_ADR_I == `ADDR_VLAN_BASE + 8'(i * 4)) begin
        rd_word = pack_entry(table_q[i]);
      end
    end
    case (WB_ADR_I)
      `ADDR_ING_FILTER:  rd_word = {16'h0000, ing_filter};
      `ADDR_EGR_TAGGED:  rd_word = {24'h000000, egr_tagged};
      `ADDR_DEF_MEMBERS: rd_word = {24'h000000, def_members};
      `ADDR_STP_STATUS:  rd_word = {24'h000000, STP_VLAN_ENABLE};
      `ADDR_FWD_COUNT:   rd_word = fwd_count;
      `ADDR_DROP_COUNT:  rd_word = drop_count;
      default: begin
      end
    endcase
  end

  // single-wait-state slave: ack one edge after the request is seen, low the next
  always_comb begin
    next_ack   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    next_dat_o = next_ack && !WB_WE_I ? rd_word : 32'h0000_0000;
    wr_en      = next_ack && WB_WE_I;
  end

  always_comb begin
    vlan_entry_t wr_entry;
    logic [31:0] merged;
    wr_entry         = '0;
    merged           = 32'h0000_0000;
    next_ing_filter  = ing_filter;
    next_egr_tagged  = egr_tagged;
    next_def_members = def_members;
    for (int p = 0; p < `NUM_PORTS; p++) begin
      next_port_default_vlan_id[p] = port_default_vlan_id[p];
      if (wr_en && WB_ADR_I == `ADDR_PORT_DEFAULT_VLAN_ID_BASE + 8'(p * 4)) begin
        merged       = merge_bytes({20'h00000, port_default_vlan_id[p]}, WB_DAT_I, WB_SEL_I);
        next_port_default_vlan_id[p] = merged[`VID_W-1:0];
      end
    end
    for (int i = 0; i < `NUM_ENTRIES; i++) begin
      next_table[i] = table_q[i];
      if (wr_en && WB_ADR_I == `ADDR_VLAN_BASE + 8'(i * 4)) begin
        wr_entry      = unpack_entry(merge_bytes(pack_entry(table_q[i]), WB_DAT_I, WB_SEL_I));
        next_table[i] = wr_entry;
        // the latest write wins: a vlan 1 write brings its ports back into the default group
        if (wr_entry.valid && wr_entry.vid != `DEFAULT_VID) begin
          next_def_members = def_members & ~wr_entry.members;
        end else if (wr_entry.valid) begin
          next_def_members = def_members | wr_entry.members;
        end
      end
    end
    if (wr_en) begin
      case (WB_ADR_I)
        `ADDR_ING_FILTER: begin
          merged          = merge_bytes({16'h0000, ing_filter}, WB_DAT_I, WB_SEL_I);
          next_ing_filter = merged[15:0];
        end
        `ADDR_EGR_TAGGED: begin
          merged          = merge_bytes({24'h000000, egr_tagged}, WB_DAT_I, WB_SEL_I);
          next_egr_tagged = merged[`NUM_PORTS-1:0];
        end
        `ADDR_DEF_MEMBERS: begin
          merged           = merge_bytes({24'h000000, def_members}, WB_DAT_I, WB_SEL_I);
          next_def_members = merged[`NUM_PORTS-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // frame decision, one cycle from RX_VALID to FWD_VALID
  always_comb begin
    // a priority-only tag (vid 0) is classified like an untagged frame
    use_port_default_vlan_id = !RX_TAGGED || RX_TCI[`VID_W-1:0] == `NULL_VID;
    cls_vid  = use_port_default_vlan_id ? port_default_vlan_id[RX_PORT] : RX_TCI[`VID_W-1:0];
    filtered = RX_TAGGED ? ing_filter[`FILT_TAG_LSB + 32'(RX_PORT)]
                         : ing_filter[`FILT_UNTAG_LSB + 32'(RX_PORT)];
    vlan_ports = lk.members;
    if (cls_vid == `DEFAULT_VID) begin
      vlan_ports = lk.members | def_members | ~lk.other_members;
    end
    src_bit = port_mask_t'(1) << RX_PORT;
    // the ingress port must itself be in the group, so disjoint vlans never mix
    drop    = filtered || ((vlan_ports & src_bit) == '0) || PORT_BLOCKING[RX_PORT];
    next_fwd_valid  = RX_VALID;
    next_fwd_drop   = RX_VALID && drop;
    next_fwd_vid    = RX_VALID ? cls_vid : FWD_VID;
    next_fwd_mask   = '0;
    next_add_tag    = '0;
    next_strip_tag  = '0;
    next_fwd_tag    = FWD_TAG;
    if (RX_VALID && !drop) begin
      next_fwd_mask  = vlan_ports & ~PORT_BLOCKING & ~src_bit;
      next_add_tag   = next_fwd_mask & egr_tagged & {`NUM_PORTS{!RX_TAGGED}};
      next_strip_tag = next_fwd_mask & ~egr_tagged & {`NUM_PORTS{RX_TAGGED}};
    end
    if (RX_VALID) begin
      // priority and dei of a received tag are carried over; untagged frames get zero
      next_fwd_tag = {`TPID_8021Q, RX_TAGGED ? RX_TCI[15:`TCI_DEI_BIT] : 4'h0, cls_vid};
    end
    next_fwd_count  = fwd_count + 32'((RX_VALID && !drop) ? 1 : 0);
    next_drop_count = drop_count + 32'((RX_VALID && drop) ? 1 : 0);
    next_stp_enable = lk.stp_enable;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        port_default_vlan_id[p] <= `DEFAULT_VID;
      end
      for (int i = 0; i < `NUM_ENTRIES; i++) begin
        table_q[i] <= '0;
      end
      ing_filter      <= `RST_ING_FILTER;
      egr_tagged      <= `RST_EGR_TAGGED;
      def_members     <= `RST_DEF_MEMBERS;
      fwd_count       <= 32'h0000_0000;
      drop_count      <= 32'h0000_0000;
      WB_ACK_O        <= 1'b0;
      WB_DAT_O        <= 32'h0000_0000;
      FWD_VALID       <= 1'b0;
      FWD_DROP        <= 1'b0;
      FWD_VID         <= `DEFAULT_VID;
      FWD_MASK        <= '0;
      FWD_ADD_TAG     <= '0;
      FWD_STRIP_TAG   <= '0;
      FWD_TAG         <= 32'h0000_0000;
      STP_VLAN_ENABLE <= '0;
    end else begin
      for (int p = 0; p < `NUM_PORTS; p++) begin
        port_default_vlan_id[p] <= next_port_default_vlan_id[p];
      end
      for (int i = 0; i < `NUM_ENTRIES; i++) begin
        table_q[i] <= next_table[i];
      end
      ing_filter      <= next_ing_filter;
      egr_tagged      <= next_egr_tagged;
      def_members     <= next_def_members;
      fwd_count       <= next_fwd_count;
      drop_count      <= next_drop_count;
      WB_ACK_O        <= next_ack;
      WB_DAT_O        <= next_dat_o;
      FWD_VALID       <= next_fwd_valid;
      FWD_DROP        <= next_fwd_drop;
      FWD_VID         <= next_fwd_vid;
      FWD_MASK        <= next_fwd_mask;
      FWD_ADD_TAG     <= next_add_tag;
      FWD_STRIP_TAG   <= next_strip_tag;
      FWD_TAG         <= next_fwd_tag;
      STP_VLAN_ENABLE <= next_stp_enable;
    end
  end
endmodule : vlan_filter

// ===== verification/vlan_filter_assertions.sv
// concurrent checks on the ports of the vlan filter
`timescale 1ns/1ps
module vlan_filter_checker (
  input wire logic                          SYS_CLK,
  input wire logic                          RESETN,
  input wire logic                          WB_CYC_I,
  input wire logic                          WB_STB_I,
  input wire logic                          WB_ACK_O,
  input wire logic                          RX_VALID,
  input wire vlan_filter_pkg::port_idx_t    RX_PORT,
  input wire logic                          RX_TAGGED,
  input wire logic [15:0]                   RX_TCI,
  input wire vlan_filter_pkg::port_mask_t   PORT_BLOCKING,
  input wire logic                          FWD_VALID,
  input wire logic                          FWD_DROP,
  input wire vlan_filter_pkg::vid_t         FWD_VID,
  input wire vlan_filter_pkg::port_mask_t   FWD_MASK,
  input wire vlan_filter_pkg::port_mask_t   FWD_ADD_TAG,
  input wire vlan_filter_pkg::port_mask_t   FWD_STRIP_TAG,
  input wire logic [31:0]                   FWD_TAG
);
  import vlan_filter_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("bus request not acked");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  a_fwd_latency: assert property (RX_VALID |=> FWD_VALID) else $error("no decision after header");
  a_no_spurious: assert property (!RX_VALID |=> !FWD_VALID && FWD_MASK == 8'h00) else $error("stray decision");
  a_drop_silent: assert property (FWD_DROP |-> FWD_VALID && FWD_MASK == 8'h00) else $error("drop with ports");
  a_block_drop: assert property (RX_VALID && PORT_BLOCKING[RX_PORT] |=> FWD_DROP) else $error("blocked ingress kept");
  a_block_stop: assert property (RX_VALID |=> (FWD_MASK & $past(PORT_BLOCKING)) == 8'h00) else $error("blocked egress");
  a_no_hairpin: assert property (RX_VALID |=> !FWD_MASK[$past(RX_PORT)]) else $error("frame sent back to ingress");
  a_add_untag: assert property (RX_VALID && RX_TAGGED |=> FWD_ADD_TAG == 8'h00) else $error("tag added twice");
  a_strip_tagged: assert property (RX_VALID && !RX_TAGGED |=> FWD_STRIP_TAG == 8'h00) else $error("strip on untagged");
  a_edit_subset: assert property (FWD_VALID |-> ((FWD_ADD_TAG | FWD_STRIP_TAG) & ~FWD_MASK) == 8'h00)
    else $error("tag edit outside mask");
  a_tag_format: assert property (FWD_VALID |-> FWD_TAG == {16'h8100, FWD_TAG[15:12], FWD_VID})
    else $error("bad tag layout");
  a_tci_kept: assert property (RX_VALID && RX_TAGGED && RX_TCI[11:0] != 12'h000 |=> FWD_TAG[15:0] == $past(RX_TCI))
    else $error("tag control changed");
  c_drop: cover property (FWD_DROP);
  c_add: cover property (FWD_ADD_TAG != 8'h00);
  c_strip: cover property (FWD_STRIP_TAG != 8'h00);
endmodule : vlan_filter_checker

bind vlan_filter vlan_filter_checker chk_u (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .RX_VALID(RX_VALID), .RX_PORT(RX_PORT), .RX_TAGGED(RX_TAGGED),
  .RX_TCI(RX_TCI), .PORT_BLOCKING(PORT_BLOCKING), .FWD_VALID(FWD_VALID), .FWD_DROP(FWD_DROP),
  .FWD_VID(FWD_VID), .FWD_MASK(FWD_MASK), .FWD_ADD_TAG(FWD_ADD_TAG), .FWD_STRIP_TAG(FWD_STRIP_TAG),
  .FWD_TAG(FWD_TAG));

// ===== verification/eth_station.sv
// station model presenting frame headers at the switch ports
`timescale 1ns/1ps
module eth_station (
  output logic                       rx_valid,
  output vlan_filter_pkg::port_idx_t rx_port,
  output logic                       rx_tagged,
  output logic [15:0]                rx_tci
);
  import vlan_filter_pkg::*;
  initial begin
    rx_valid = 1'b0;
    rx_port = 3'h0;
    rx_tagged = 1'b0;
    rx_tci = 16'h0000;
  end
  task send(input port_idx_t p, input logic t, input logic [15:0] c);
    rx_valid <= 1'b1;
    rx_port <= p;
    rx_tagged <= t;
    rx_tci <= c;
  endtask : send
  // port and tci lines change once when the port goes idle after a burst so stale values never look valid
  task idle();
    rx_valid <= 1'b0;
    rx_port <= rx_port + 3'h1;
    rx_tci <= ~rx_tci;
  endtask : idle
endmodule : eth_station

// ===== verification/test_vlan_filter.sv
// self-checking bench for the vlan filter
`timescale 1ns/1ps
`include "vlan_filter_map.svh"
module test_vlan_filter;
  import vlan_filter_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, fwd_tag;
  logic rx_valid, rx_tagged, fwd_valid, fwd_drop;
  logic [15:0] rx_tci, filt = 16'h0;
  port_idx_t rx_port;
  port_mask_t blk = 8'h00, fwd_mask, fwd_add, fwd_strip, m5 = 8'h00, m7 = 8'h00, defm = 8'hFF, egr = 8'h00;
  entry_mask_t stp_en;
  vid_t fwd_vid;
  vid_t vids [5] = '{12'h000, 12'h001, 12'h005, 12'h007, 12'h009};
  logic [36:0] fq [$];
  logic [31:0] rq [$];
  logic [31:0] tq [$];
  int n_mismatch = 0, samples_checked = 0, nfwd = 0, ndrop = 0;

  always #2 sys_clk = ~sys_clk;

  eth_station st_u (.rx_valid(rx_valid), .rx_port(rx_port), .rx_tagged(rx_tagged), .rx_tci(rx_tci));
  vlan_filter dut_u (.SYS_CLK(sys_clk), .RESETN(resetn), .WB_ADR_I(adr), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .RX_VALID(rx_valid),
    .RX_PORT(rx_port), .RX_TAGGED(rx_tagged), .RX_TCI(rx_tci), .PORT_BLOCKING(blk), .FWD_VALID(fwd_valid),
    .FWD_DROP(fwd_drop), .FWD_VID(fwd_vid), .FWD_MASK(fwd_mask), .FWD_ADD_TAG(fwd_add),
    .FWD_STRIP_TAG(fwd_strip), .FWD_TAG(fwd_tag), .STP_VLAN_ENABLE(stp_en));

  task chk(input logic [36:0] s, input logic [36:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // port 2 defaults to vid 5, every other port to vid 1
  function automatic logic [36:0] expect_frame(port_idx_t p, logic t, vid_t v, port_mask_t b);
    vid_t c;
    port_mask_t m;
    logic d;
    c = (!t || v == 12'h000) ? ((p == 3'h2) ? 12'h005 : 12'h001) : v;
    m = (c == 12'h005) ? m5 : (c == 12'h007) ? m7 : (c == 12'h001) ? (defm | ~(m5 | m7)) : 8'h00;
    d = (t ? filt[{1'b0, p}] : filt[{1'b1, p}]) | ~m[p] | b[p];
    m = d ? 8'h00 : (m & ~b & ~(8'h01 << p));
    return {d, c, m, t ? 8'h00 : (m & egr), t ? (m & ~egr) : 8'h00};
  endfunction : expect_frame

  task wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
    int n;
    n = 0;
    if (!w) rq.push_back(e);
    @(posedge sys_clk);
    adr <= a;
    we <= w;
    dat_i <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task frames(input int n);
    port_idx_t p;
    logic t;
    logic [15:0] c;
    port_mask_t b;
    logic [36:0] e;
    for (int i = 0; i < n; i++) begin
      p = 3'($urandom_range(7));
      t = 1'($urandom);
      c = {4'($urandom), vids[$urandom_range(4)]};
      b = ($urandom_range(3) == 0) ? 8'($urandom) : 8'h00;
      e = expect_frame(p, t, c[11:0], b);
      fq.push_back(e);
      // priority and dei only survive from a received tag
      tq.push_back({16'h8100, t ? c[15:12] : 4'h0, e[35:24]});
      if (e[36]) ndrop++;
      else nfwd++;
      @(posedge sys_clk);
      st_u.send(p, t, c);
      blk <= b;
    end
    @(posedge sys_clk);
    st_u.idle();
  endtask : frames

  always @(posedge sys_clk) begin
    if (fwd_valid === 1'b1) chk({fwd_drop, fwd_vid, fwd_mask, fwd_add, fwd_strip}, fq.pop_front());
    if (fwd_valid === 1'b1) chk({5'h00, fwd_tag}, {5'h00, tq.pop_front()});
    if (ack === 1'b1 && we === 1'b0) chk({5'h00, dat_o}, {5'h00, rq.pop_front()});
  end

  initial begin
    #40000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hFB237FA7));
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    wb(`ADDR_PORT_DEFAULT_VLAN_ID_BASE + 8'h1C, 1'b0, 32'h0, 32'h1);
    wb(`ADDR_DEF_MEMBERS, 1'b0, 32'h0, 32'hFF);
    wb(8'h80, 1'b1, 32'hFFFFFFFF, 32'h0);
    wb(8'h80, 1'b0, 32'h0, 32'h0);
    // port 2 moves to vid 5 before any frame, as the expectation model assumes
    wb(`ADDR_PORT_DEFAULT_VLAN_ID_BASE + 8'h08, 1'b1, 32'h5, 32'h0);
    frames(20);
    wb(`ADDR_EGR_TAGGED, 1'b1, 32'h02, 32'h0);
    egr = 8'h02;
    wb(`ADDR_VLAN_BASE, 1'b1, 32'h800F0005, 32'h0);
    wb(`ADDR_VLAN_BASE + 8'h04, 1'b1, 32'h80180007, 32'h0);
    {m5, m7, defm} = {8'h0F, 8'h18, 8'hE0};
    wb(`ADDR_DEF_MEMBERS, 1'b0, 32'h0, 32'hE0);
    wb(`ADDR_STP_STATUS, 1'b1, 32'hFF, 32'h0);
    wb(`ADDR_STP_STATUS, 1'b0, 32'h0, 32'h01);
    chk({29'h0, stp_en}, 37'h01);
    frames(100);
    wb(`ADDR_ING_FILTER, 1'b1, 32'h0201, 32'h0);
    filt = 16'h0201;
    // vid 1 configured last puts port 0 back into the default group
    wb(`ADDR_VLAN_BASE + 8'h08, 1'b1, 32'h80010001, 32'h0);
    defm = 8'hE1;
    wb(`ADDR_STP_STATUS, 1'b0, 32'h0, 32'h04);
    chk({29'h0, stp_en}, 37'h04);
    wb(`ADDR_DEF_MEMBERS, 1'b0, 32'h0, 32'hE1);
    frames(100);
    repeat (4) @(posedge sys_clk);
    wb(`ADDR_FWD_COUNT, 1'b0, 32'h0, 32'(nfwd));
    wb(`ADDR_DROP_COUNT, 1'b0, 32'h0, 32'(ndrop));
    repeat (2) @(posedge sys_clk);
    end_of_test();
  end
endmodule : test_vlan_filter
